/* core/epi_map.svh */
// Widths, counts, field positions and channel and ID codes for the external port block
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH
`define EPI_DATA_W 48
`define EPI_ADDR_W 32
`define EPI_NBANK 4
`define EPI_NPROC 6
`define EPI_W32_LSB 16
`define EPI_W40_LSB 8
`define EPI_W16_LSB 16
`define EPI_BANK_LSB 26
`define EPI_DMA_CH_ONE 3'h7
`define EPI_DMA_CH_TWO 3'h6
`define EPI_ID_SINGLE 3'h0
`endif

/* core/epi_pkg.sv */
// Types for the external port block
package epi_pkg;
	typedef enum logic [2:0] {
		EPI_FMT_W32 = 3'h1,
		EPI_FMT_W40 = 3'h2,
		EPI_FMT_W16 = 3'h4
	} epi_fmt_t;
	typedef enum logic [4:0] {
		EPI_IDLE = 5'h01,
		EPI_ADDR = 5'h02,
		EPI_STRB = 5'h04,
		EPI_HALT = 5'h08,
		EPI_HOST = 5'h10
	} epi_state_t;
endpackage : epi_pkg

/* core/epi_lane.sv */
// Data lane placement for the three word formats
`timescale 1ns/1ps
`include "epi_map.svh"
module epi_lane (
	input wire epi_pkg::epi_fmt_t fmt,
	input wire logic [39:0] word_in,
	input wire logic [`EPI_DATA_W-1:0] bus_in,
	output logic [`EPI_DATA_W-1:0] bus_out,
	output logic [39:0] word_out
);
	import epi_pkg::*;
	always_comb begin
		bus_out = '0;
		word_out = '0;
		case (fmt)
			EPI_FMT_W40: begin
				bus_out[47:`EPI_W40_LSB] = word_in; // [RULE1]
				word_out = bus_in[47:`EPI_W40_LSB];
			end
			EPI_FMT_W16: begin
				bus_out[31:`EPI_W16_LSB] = word_in[15:0]; // [RULE1]
				word_out = {24'h000000, bus_in[31:`EPI_W16_LSB]};
			end
			default: begin
				bus_out[47:`EPI_W32_LSB] = word_in[31:0]; // [RULE1]
				word_out = {8'h00, bus_in[47:`EPI_W32_LSB]};
			end
		endcase
	end
endmodule : epi_lane

/* core/epi_arb.sv */
// Multiprocessor bus arbitration, fixed or rotating priority
`timescale 1ns/1ps
`include "epi_map.svh"
module epi_arb (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] node_number,
	input wire logic priority_rotation_select,
	input wire logic want_bus,
	input wire logic [`EPI_NPROC-1:0] arb_req_in_n,
	output logic arb_req_out_n,
	output logic arb_req_oe,
	output logic is_master
);
	import epi_pkg::*;
	logic [2:0] last_q, last_d;
	logic master_q, master_d;
	logic [`EPI_NPROC-1:0] reqs;
	logic [2:0] winner;
	logic any;
	logic [2:0] idx;
	// Own line is driven only in multiprocessor systems
	assign arb_req_oe = (node_number != `EPI_ID_SINGLE); // [RULE19]
	assign arb_req_out_n = ~want_bus;
	assign is_master = (node_number == `EPI_ID_SINGLE) ? want_bus : master_q;
	always_comb begin
		reqs = ~arb_req_in_n;
		if (node_number != `EPI_ID_SINGLE)
			reqs[node_number - 3'h1] = want_bus; // [RULE19]
		winner = 3'h0;
		any = 1'b0;
		idx = 3'h0;
		for (int i = `EPI_NPROC - 1; i >= 0; i--) begin
			if (priority_rotation_select) // [RULE20]
				idx = 3'((int'(last_q) + 1 + i) % `EPI_NPROC);
			else
				idx = 3'(i);
			if (reqs[idx]) begin
				winner = idx;
				any = 1'b1;
			end
		end
		// Sticky mastership: current master keeps bus while requesting
		master_d = master_q;
		last_d = last_q;
		if (!(master_q && want_bus)) begin
			master_d = any && (winner == node_number - 3'h1) && want_bus;
			if (any)
				last_d = winner;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			master_q <= 1'b0;
			last_q <= 3'h0;
		end else begin
			master_q <= master_d;
			last_q <= last_d;
		end
	end
endmodule : epi_arb

/* core/epi_port.sv */
// External parallel port: strobes, selects, host grant, ready and DMA handshakes
`timescale 1ns/1ps
`include "epi_map.svh"
// Behaviour
// [RULE1] 32-bit words on bits 47-16, 40-bit on 47-8, 16-bit on 31-16.
// [RULE2] Bank selects are decoded address, switch with address, idle when no access.
// [RULE3] Conditional access asserts its bank select even when condition is false.
// [RULE4] Page output flags DRAM page crossing for bank 0 only, per page size.
// [RULE5] Device drives read strobe for own reads; external master drives it inward.
// [RULE6] Device drives write strobe for own writes; external master drives it inward.
// [RULE7] Address is valid before the rising edge of the address latch clock.
// [RULE8] Early write select goes with address; no later write strobe means aborted.
// [RULE9] Host synchronous writes assert the write select to mark a write.
// [RULE10] Far devices hold acknowledge low to stretch the device's access.
// [RULE11] As slave, pull acknowledge low for waits; master's input keeps last level.
// [RULE12] Bus suspend low tristates address, data, selects, strobes next cycle.
// [RULE13] Access during bus suspend halts and completes after suspend releases.
// [RULE14] Host request: master tristates bus and grants; host beats all processors.
// [RULE15] Host grant held low until host request released; others only monitor. Here any node with grant_q set drives it too.
// [RULE16] Host ready low adds waits; driven only with chip select and host request.
// [RULE17] Host ready open drain after reset; active drive when ready-drive bit set.
// [RULE18] DMA pair one serves channel 7, pair two serves channel 6.
// [RULE19] Drive only own bus request line chosen by node number; 000 is single.
// [RULE20] Rotating priority when select is high, fixed when low.
// [RULE21] System applies identical priority select to all, changed in same cycle.
// [RULE22] Slave core may assert shared open-drain core priority to preempt DMA.
module epi_port (
	input wire logic mclk,
	input wire logic rst,
	// Internal request side
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_cond_false,
	input wire epi_pkg::epi_fmt_t req_fmt,
	input wire logic [`EPI_ADDR_W-1:0] req_addr,
	input wire logic [39:0] req_wdata,
	input wire logic [2:0] page_size_sel,
	input wire logic ready_drive_select,
	input wire logic slave_busy,
	input wire logic core_wants_bus,
	output logic req_done,
	output logic [39:0] rd_word,
	output logic core_halted,
	// Address and data pins
	input wire logic [`EPI_ADDR_W-1:0] addr_in,
	output logic [`EPI_ADDR_W-1:0] addr_out,
	output logic addr_oe,
	input wire logic [`EPI_DATA_W-1:0] data_in,
	output logic [`EPI_DATA_W-1:0] data_out,
	output logic data_oe,
	output logic [`EPI_NBANK-1:0] bank_select_n,
	output logic page,
	output logic address_latch_clock,
	// Strobes
	input wire logic rd_n_in,
	output logic rd_n_out,
	input wire logic wr_n_in,
	output logic wr_n_out,
	input wire logic sync_write_select_n_in,
	output logic sync_write_select_n_out,
	output logic strobe_oe,
	input wire logic ack_in,
	output logic ack_out,
	output logic ack_oe,
	input wire logic bus_suspend_n,
	// Host
	input wire logic host_bus_request_n,
	input wire logic host_cs_n,
	input wire logic host_grant_n_in,
	output logic host_grant_n_out,
	output logic host_grant_oe,
	output logic host_wait_ready_n,
	output logic host_wait_ready_oe,
	output logic host_access,
	output logic host_is_write,
	// DMA handshakes
	input wire logic dma_request_one_n,
	input wire logic dma_request_two_n,
	input wire logic dma_grant_one_cmd,
	input wire logic dma_grant_two_cmd,
	output logic [2:0] dma_req_chan,
	output logic dma_req_valid,
	output logic dma_grant_one_n,
	output logic dma_grant_two_n,
	// Multiprocessor
	input wire logic [2:0] node_number,
	input wire logic priority_rotation_select,
	input wire logic [`EPI_NPROC-1:0] arbitration_request_n_in,
	output logic arbitration_request_n_out,
	output logic arbitration_request_oe,
	input wire logic core_priority_n_in,
	output logic core_priority_oe,
	output logic dma_preempted
);
	import epi_pkg::*;
	epi_state_t st_q, st_d;
	logic [`EPI_ADDR_W-1:0] addr_q, addr_d;
	logic [`EPI_DATA_W-1:0] dout_q, dout_d;
	logic [`EPI_NBANK-1:0] bank_q, bank_d;
	logic page_q, page_d, rd_q, rd_d, wr_q, wr_d, sw_q, sw_d;
	logic write_q, write_d, cond_q, cond_d;
	logic susp_q, susp_d, grant_q, grant_d, alck_q, alck_d;
	logic [`EPI_ADDR_W-1:0] last_row_q, last_row_d;
	logic row_valid_q, row_valid_d;
	logic [39:0] rword_q, rword_d;
	epi_fmt_t fmt_q, fmt_d;
	epi_fmt_t lane_fmt;
	logic done_q, done_d;
	logic [`EPI_DATA_W-1:0] lane_bus;
	logic [39:0] lane_word;
	logic is_master, want_bus, host_req, drive_bus;

	function automatic logic [`EPI_NBANK-1:0] bank_decode(input logic [`EPI_ADDR_W-1:0] a);
		logic [`EPI_NBANK-1:0] sel;
		sel = '1;
		if (a[`EPI_ADDR_W-1:`EPI_BANK_LSB + 2] == '0)
			sel[a[`EPI_BANK_LSB +: 2]] = 1'b0;
		return sel;
	endfunction : bank_decode

	// Page size is a power of two words selected by page_size_sel
	function automatic logic [`EPI_ADDR_W-1:0] row_of(input logic [`EPI_ADDR_W-1:0] a,
		input logic [2:0] sz);
		return a >> (5'h8 + {2'h0, sz});
	endfunction : row_of

	// Writes are placed at take time; reads unpack with the format stored then
	always_comb begin
		if (st_q == EPI_IDLE)
			lane_fmt = req_fmt;
		else
			lane_fmt = fmt_q;
	end

	epi_lane u_lane (
		.fmt(lane_fmt),
		.word_in(req_wdata),
		.bus_in(data_in),
		.bus_out(lane_bus),
		.word_out(lane_word)
	);

	epi_arb u_arb (
		.mclk(mclk),
		.rst(rst),
		.node_number(node_number),
		.priority_rotation_select(priority_rotation_select), // [RULE21]
		.want_bus(want_bus),
		.arb_req_in_n(arbitration_request_n_in),
		.arb_req_out_n(arbitration_request_n_out),
		.arb_req_oe(arbitration_request_oe),
		.is_master(is_master)
	);

	assign host_req = ~host_bus_request_n;
	assign want_bus = (req_valid || st_q != EPI_IDLE) && !grant_q;
	// Suspend and host grant both float the bus
	assign drive_bus = is_master && !susp_q && !grant_q; // [RULE12] [RULE14]
	assign addr_out = addr_q;
	assign data_out = dout_q;
	assign addr_oe = drive_bus;
	assign data_oe = drive_bus && write_q && (st_q == EPI_STRB);
	assign strobe_oe = drive_bus;
	assign bank_select_n = drive_bus ? bank_q : '1;
	assign page = page_q;
	assign rd_n_out = rd_q; // [RULE5]
	assign wr_n_out = wr_q; // [RULE6]
	assign sync_write_select_n_out = sw_q;
	assign address_latch_clock = alck_q; // [RULE7]
	assign req_done = done_q;
	assign rd_word = rword_q;
	assign core_halted = (st_q == EPI_HALT); // [RULE13]
	// The master and any node holding grant_q drive grant; others float it, and host_grant_n_in is never read
	assign host_grant_n_out = ~grant_q; // [RULE15]
	assign host_grant_oe = is_master || grant_q; // [RULE15]
	// Inbound access by an outside master; write flagged by sync write select
	assign host_access = !is_master && (!rd_n_in || !wr_n_in);
	assign host_is_write = !sync_write_select_n_in || !wr_n_in; // [RULE9]
	assign ack_out = 1'b0;
	assign ack_oe = host_access && slave_busy; // [RULE11]
	assign host_wait_ready_n = ~(ready_drive_select ? 1'b1 : 1'b0) | slave_busy ? 1'b0 : 1'b1;
	// Open drain only pulls low; active drive also drives high
	assign host_wait_ready_oe = !host_cs_n && host_req &&
		(slave_busy || ready_drive_select); // [RULE16] [RULE17]
	assign dma_req_valid = !dma_request_one_n || !dma_request_two_n;
	assign dma_req_chan = !dma_request_one_n ? `EPI_DMA_CH_ONE : `EPI_DMA_CH_TWO; // [RULE18]
	assign dma_grant_one_n = ~dma_grant_one_cmd; // [RULE18]
	assign dma_grant_two_n = ~dma_grant_two_cmd; // [RULE18]
	assign core_priority_oe = !is_master && core_wants_bus; // [RULE22]
	assign dma_preempted = is_master && !core_priority_n_in; // [RULE22]

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		dout_d = dout_q;
		bank_d = '1;
		page_d = 1'b0;
		rd_d = 1'b1;
		wr_d = 1'b1;
		sw_d = 1'b1;
		write_d = write_q;
		cond_d = cond_q;
		fmt_d = fmt_q;
		rword_d = rword_q;
		done_d = 1'b0;
		alck_d = ~alck_q;
		last_row_d = last_row_q;
		row_valid_d = row_valid_q;
		susp_d = !bus_suspend_n; // [RULE12]
		// Host wins over all processor requests and holds until release
		grant_d = host_req && (grant_q || st_q == EPI_IDLE || !is_master); // [RULE14]
		case (st_q)
			EPI_IDLE: begin
				if (req_valid && !grant_d) begin
					addr_d = req_addr;
					dout_d = lane_bus;
					write_d = req_write;
					cond_d = req_cond_false;
					fmt_d = req_fmt;
					// Selects and early write select switch together with the address
					bank_d = bank_decode(req_addr); // [RULE2] [RULE3]
					sw_d = ~req_write; // [RULE8]
					// Latch clock held low so it never rises while the address moves
					alck_d = 1'b0; // [RULE7]
					st_d = !bus_suspend_n ? EPI_HALT : EPI_ADDR; // [RULE13]
				end
			end
			EPI_HALT: begin
				bank_d = bank_q;
				sw_d = sw_q;
				alck_d = 1'b0;
				if (bus_suspend_n)
					st_d = EPI_ADDR; // [RULE13]
			end
			EPI_ADDR: begin
				bank_d = bank_q;
				sw_d = sw_q;
				alck_d = 1'b0;
				if (is_master) begin
					alck_d = 1'b1; // [RULE7]
					// Strobes open with the strobe state so ack is judged on a live strobe
					// False condition keeps selects but withholds strobes
					rd_d = write_q || cond_q; // [RULE5]
					wr_d = !write_q || cond_q; // [RULE6] [RULE8]
					if (bank_q == 4'he) begin
						page_d = row_valid_q &&
							(row_of(addr_q, page_size_sel) != last_row_q); // [RULE4]
						last_row_d = row_of(addr_q, page_size_sel);
						row_valid_d = 1'b1;
					end
					st_d = EPI_STRB;
				end
			end
			EPI_STRB: begin
				bank_d = bank_q; // [RULE3]
				sw_d = sw_q;
				alck_d = 1'b1; // [RULE7]
				rd_d = rd_q;
				wr_d = wr_q;
				if (ack_in && !susp_q) begin // [RULE10]
					bank_d = '1; // [RULE2]
					sw_d = 1'b1;
					rd_d = 1'b1;
					wr_d = 1'b1;
					if (!write_q && !cond_q)
						rword_d = lane_word;
					done_d = 1'b1;
					st_d = EPI_IDLE;
				end
			end
			default: st_d = EPI_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= EPI_IDLE;
			addr_q <= '0;
			dout_q <= '0;
			bank_q <= '1;
			page_q <= 1'b0;
			rd_q <= 1'b1;
			wr_q <= 1'b1;
			sw_q <= 1'b1;
			write_q <= 1'b0;
			cond_q <= 1'b0;
			fmt_q <= EPI_FMT_W32;
			rword_q <= '0;
			done_q <= 1'b0;
			alck_q <= 1'b0;
			last_row_q <= '0;
			row_valid_q <= 1'b0;
			susp_q <= 1'b0;
			grant_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
			bank_q <= bank_d;
			page_q <= page_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			sw_q <= sw_d;
			write_q <= write_d;
			cond_q <= cond_d;
			fmt_q <= fmt_d;
			rword_q <= rword_d;
			done_q <= done_d;
			alck_q <= alck_d;
			last_row_q <= last_row_d;
			row_valid_q <= row_valid_d;
			susp_q <= susp_d;
			grant_q <= grant_d;
		end
	end
endmodule : epi_port

/* testbench/epi_port_properties.sv */
// Concurrent checks on the external port pins
`timescale 1ns/1ps
`include "epi_map.svh"
module epi_port_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic strobe_oe,
	input wire logic addr_oe,
	input wire logic data_oe,
	input wire logic [`EPI_NBANK-1:0] bank_select_n,
	input wire logic bus_suspend_n,
	input wire logic host_bus_request_n,
	input wire logic host_grant_n_out,
	input wire logic host_cs_n,
	input wire logic host_wait_ready_n,
	input wire logic host_wait_ready_oe,
	input wire logic ready_drive_select,
	input wire logic dma_req_valid,
	input wire logic dma_request_one_n,
	input wire logic [2:0] dma_req_chan,
	input wire logic [2:0] node_number,
	input wire logic arbitration_request_oe,
	input wire logic wr_n_out,
	input wire logic rd_n_out,
	input wire logic sync_write_select_n_out,
	input wire logic ack_in,
	input wire logic ack_oe,
	input wire logic ack_out,
	input wire logic slave_busy,
	input wire logic req_done,
	input wire logic core_halted,
	input wire logic address_latch_clock,
	input wire logic [`EPI_ADDR_W-1:0] addr_out
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_idle_selects: assert property (!strobe_oe |-> bank_select_n == 4'hf)
		else $error("Bank select active with bus released");
	a_suspend_float: assert property (!bus_suspend_n |=> !addr_oe && !data_oe && !strobe_oe)
		else $error("Bus driven after suspend");
	a_halt_quiet: assert property (core_halted |-> !req_done && !strobe_oe)
		else $error("Access progressed while halted");
	a_grant_float: assert property (!host_grant_n_out |-> !addr_oe && !strobe_oe)
		else $error("Bus driven while host granted");
	a_grant_hold: assert property (!host_grant_n_out && !host_bus_request_n |=> !host_grant_n_out)
		else $error("Host grant dropped early");
	a_ready_gate: assert property (host_wait_ready_oe |-> !host_cs_n && !host_bus_request_n)
		else $error("Ready driven without select and request");
	a_ready_od: assert property (host_wait_ready_oe && !ready_drive_select |-> !host_wait_ready_n)
		else $error("Ready driven high in open drain mode");
	a_dma_map: assert property (dma_req_valid |-> dma_req_chan == (!dma_request_one_n ? 3'h7 : 3'h6))
		else $error("Wrong DMA channel");
	a_arb_own: assert property (arbitration_request_oe == (node_number != 3'h0))
		else $error("Bus request line drive wrong");
	a_sw_early: assert property ($fell(wr_n_out) |-> $past(sync_write_select_n_out) == 1'b0)
		else $error("Write strobe without early write select");
	a_wait_stretch: assert property (!rd_n_out && !ack_in |=> !rd_n_out)
		else $error("Read strobe ended during wait");
	a_slave_ack: assert property (ack_oe |-> !ack_out && slave_busy)
		else $error("Acknowledge driven wrongly");
	a_addr_before_latch: assert property ($rose(address_latch_clock) |-> $stable(addr_out))
		else $error("Address moved at the latch clock rise");
	cover property (req_done);
	cover property (!host_grant_n_out);
	cover property (core_halted);
endmodule : epi_port_properties
bind epi_port epi_port_properties u_props (.*);

/* testbench/epi_mem_model.sv */
// Far-side memory with programmable wait states
`timescale 1ns/1ps
module epi_mem_model (
	input wire logic mclk,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [31:0] addr,
	input wire logic [47:0] wdata,
	input wire logic [3:0] waits,
	output logic ack,
	output logic [47:0] rdata
);
	logic [47:0] mem [16];
	logic [3:0] cnt = 4'h0;
	logic [47:0] last = 48'h0;
	// Ack held low until the wait count runs out
	assign ack = (rd_n && wr_n) || (cnt >= waits);
	// Released lines toggle so a stale value is never mistaken for data
	assign rdata = !rd_n ? mem[addr[3:0]] : ~last;
	always @(posedge mclk) begin
		last <= rdata;
		cnt <= (rd_n && wr_n) ? 4'h0 : cnt + 4'h1;
		if (!wr_n && ack) begin
			mem[addr[3:0]] <= wdata;
		end
	end
endmodule : epi_mem_model

/* testbench/testbench.sv */
// Self-checking bench for the external port block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	import epi_pkg::*;
	logic mclk, rst, req_valid, req_write, req_cond_false, ready_drive_select, slave_busy;
	logic core_wants_bus, req_done, core_halted, addr_oe, data_oe, page, address_latch_clock;
	logic rd_n_in, rd_n_out, wr_n_in, wr_n_out, sync_write_select_n_in, sync_write_select_n_out;
	logic strobe_oe, ack_in, ack_out, ack_oe, bus_suspend_n, host_bus_request_n, host_cs_n;
	logic host_grant_n_in, host_grant_n_out, host_grant_oe, host_wait_ready_n, host_wait_ready_oe;
	logic host_access, host_is_write, dma_request_one_n, dma_request_two_n, dma_grant_one_cmd;
	logic dma_grant_two_cmd, dma_req_valid, dma_grant_one_n, dma_grant_two_n, mem_ack, ext_rd_n;
	logic priority_rotation_select, arbitration_request_n_out, arbitration_request_oe;
	logic core_priority_n_in, core_priority_oe, dma_preempted, seen_wr, seen_sw;
	logic ext_sw_n, peer_req_n;
	epi_fmt_t req_fmt;
	logic [31:0] req_addr, addr_in, addr_out;
	logic [39:0] req_wdata, rd_word;
	logic [2:0] page_size_sel, node_number, dma_req_chan;
	logic [47:0] data_in, data_out, last_wr;
	logic [3:0] bank_select_n, sel_seen, waits;
	logic [5:0] arbitration_request_n_in;
	logic [7:0] rd_low, pages;
	int failures = 0;
	int total_checks = 0;
	assign rd_n_in = strobe_oe ? rd_n_out : ext_rd_n;
	assign wr_n_in = strobe_oe ? wr_n_out : 1'b1;
	assign sync_write_select_n_in = strobe_oe ? sync_write_select_n_out : ext_sw_n;
	assign ack_in = ack_oe ? ack_out : mem_ack;
	assign addr_in = addr_oe ? addr_out : 32'h0;
	assign host_grant_n_in = host_grant_oe ? host_grant_n_out : 1'b1;
	assign arbitration_request_n_in = {4'hf, arbitration_request_n_out | ~arbitration_request_oe,
		peer_req_n};
	assign core_priority_n_in = ~core_priority_oe;
	epi_port u_dut (.*);
	epi_mem_model u_mem (.mclk, .rd_n(rd_n_out | ~strobe_oe), .wr_n(wr_n_out | ~strobe_oe),
		.addr(addr_out), .wdata(data_out), .waits, .ack(mem_ack), .rdata(data_in));
	always @(posedge mclk) begin
		if (!wr_n_out && strobe_oe) last_wr <= data_out;
		if (!wr_n_out && strobe_oe) seen_wr <= 1'b1;
		if (!sync_write_select_n_out && strobe_oe) seen_sw <= 1'b1;
		if (!rd_n_out && strobe_oe) rd_low <= rd_low + 8'h1;
		if (bank_select_n != 4'hf) sel_seen <= bank_select_n;
		if (page === 1'b1) pages <= pages + 8'h1;
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic tally_and_finish(input bit timed_out);
		if (timed_out) failures++;
		if (failures == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic start_req(input logic w, c, input epi_fmt_t f, input logic [31:0] a,
		input logic [39:0] d);
		req_write = w;
		req_cond_false = c;
		req_fmt = f;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
	endtask : start_req
	task automatic wait_done();
		int i;
		for (i = 0; i < 80 && req_done !== 1'b1; i++) tick();
		if (i == 80) tally_and_finish(1'b1);
		tick();
	endtask : wait_done
	task automatic access(input logic w, c, input epi_fmt_t f, input logic [31:0] a,
		input logic [39:0] d);
		start_req(w, c, f, a, d);
		wait_done();
	endtask : access
	task automatic wait_grant(input logic v);
		int i;
		for (i = 0; i < 20 && host_grant_n_out !== v; i++) tick();
		if (i == 20) tally_and_finish(1'b1);
	endtask : wait_grant
	task automatic t_lanes();
		epi_fmt_t f [3] = '{EPI_FMT_W32, EPI_FMT_W40, EPI_FMT_W16};
		logic [47:0] m [3] = '{48'hffff_ffff_0000, 48'hffff_ffff_ff00, 48'h0000_ffff_0000};
		logic [39:0] r [3] = '{40'h00_ffff_ffff, 40'hff_ffff_ffff, 40'h00_0000_ffff};
		logic [39:0] d;
		logic [47:0] e;
		for (int i = 0; i < 3; i++) begin
			d = 40'h12_3456_789a + 40'(i);
			e = i == 1 ? {d, 8'h0} : {d[31:0], 16'h0};
			waits = 4'h0;
			access(1'b1, 1'b0, f[i], 32'h0800_0000 + 32'(i), d);
			`CHK(sel_seen, 4'hb)
			`CHK(last_wr & m[i], e & m[i])
			waits = 4'h2;
			rd_low = 8'h0;
			access(1'b0, 1'b0, f[i], 32'h0800_0000 + 32'(i), 40'h0);
			`CHK(rd_low, 8'h3)
			`CHK(rd_word & r[i], d & r[i])
		end
		waits = 4'h0;
	endtask : t_lanes
	task automatic t_cond();
		seen_wr = 1'b0;
		seen_sw = 1'b0;
		access(1'b1, 1'b1, EPI_FMT_W32, 32'h0400_0005, 40'h5);
		`CHK(sel_seen, 4'hd)
		`CHK(seen_sw, 1'b1)
		`CHK(seen_wr, 1'b0)
	endtask : t_cond
	task automatic t_page();
		pages = 8'h0;
		access(1'b0, 1'b0, EPI_FMT_W32, 32'h0, 40'h0);
		access(1'b0, 1'b0, EPI_FMT_W32, 32'h100, 40'h0);
		`CHK(pages, 8'h1)
		pages = 8'h0;
		access(1'b0, 1'b0, EPI_FMT_W32, 32'h0400_0000, 40'h0);
		access(1'b0, 1'b0, EPI_FMT_W32, 32'h0400_0100, 40'h0);
		`CHK(pages, 8'h0)
	endtask : t_page
	task automatic t_suspend();
		bus_suspend_n = 1'b0;
		start_req(1'b0, 1'b0, EPI_FMT_W32, 32'h0800_0001, 40'h0);
		tick(3);
		`CHK(core_halted, 1'b1)
		`CHK(strobe_oe, 1'b0)
		bus_suspend_n = 1'b1;
		wait_done();
	endtask : t_suspend
	task automatic t_host();
		host_bus_request_n = 1'b0;
		wait_grant(1'b0);
		`CHK(addr_oe, 1'b0)
		tick(5);
		`CHK(host_grant_n_out, 1'b0)
		host_cs_n = 1'b0;
		slave_busy = 1'b1;
		ext_rd_n = 1'b0;
		tick();
		`CHK({host_wait_ready_oe, host_wait_ready_n}, 2'b10)
		`CHK({ack_oe, ack_out, host_access, host_is_write}, 4'ha)
		ext_rd_n = 1'b1;
		ext_sw_n = 1'b0;
		slave_busy = 1'b0;
		tick();
		`CHK(host_is_write, 1'b1)
		`CHK(host_wait_ready_oe, 1'b0)
		ext_sw_n = 1'b1;
		ready_drive_select = 1'b1;
		tick();
		`CHK({host_wait_ready_oe, host_wait_ready_n}, 2'b11)
		host_cs_n = 1'b1;
		tick();
		`CHK(host_wait_ready_oe, 1'b0)
		ready_drive_select = 1'b0;
		host_bus_request_n = 1'b1;
		wait_grant(1'b1);
	endtask : t_host
	task automatic t_dma();
		dma_request_one_n = 1'b0;
		tick();
		`CHK({dma_req_valid, dma_req_chan}, 4'hf)
		dma_request_one_n = 1'b1;
		dma_request_two_n = 1'b0;
		dma_grant_two_cmd = 1'b1;
		tick();
		`CHK({dma_req_valid, dma_req_chan, dma_grant_two_n}, 5'h1c)
		dma_request_two_n = 1'b1;
		dma_grant_two_cmd = 1'b0;
		dma_grant_one_cmd = 1'b1;
		tick();
		`CHK(dma_grant_one_n, 1'b0)
		dma_grant_one_cmd = 1'b0;
	endtask : t_dma
	task automatic t_arb();
		`CHK(arbitration_request_oe, 1'b0)
		node_number = 3'h2;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick();
		`CHK(arbitration_request_oe, 1'b1)
		access(1'b0, 1'b0, EPI_FMT_W32, 32'h0800_0000, 40'h0);
		`CHK(rd_word[31:0], 32'h3456_789a)
		// Peer on line one outranks line two under fixed priority
		peer_req_n = 1'b0;
		core_wants_bus = 1'b1;
		start_req(1'b0, 1'b0, EPI_FMT_W32, 32'h0800_0002, 40'h0);
		tick(4);
		`CHK({req_done, strobe_oe, core_halted}, 3'h0)
		`CHK(core_priority_oe, 1'b1)
		core_wants_bus = 1'b0;
		priority_rotation_select = 1'b1;
		wait_done();
		`CHK(rd_word, 40'h00_0000_789c)
		peer_req_n = 1'b1;
		priority_rotation_select = 1'b0;
	endtask : t_arb
	initial begin
		{rst, req_valid, req_write, req_cond_false, ready_drive_select, slave_busy} = 6'h20;
		{core_wants_bus, priority_rotation_select, dma_grant_one_cmd, dma_grant_two_cmd} = 4'h0;
		{bus_suspend_n, host_bus_request_n, host_cs_n, ext_rd_n} = 4'hf;
		{ext_sw_n, peer_req_n} = 2'h3;
		{dma_request_one_n, dma_request_two_n, seen_wr, seen_sw} = 4'hc;
		req_fmt = EPI_FMT_W32;
		{req_addr, req_wdata, page_size_sel, node_number} = 78'h0;
		{waits, rd_low, pages, sel_seen, last_wr} = {4'h0, 16'h0, 4'hf, 48'h0};
		tick(12);
		rst = 1'b0;
		tick();
		t_lanes();
		t_cond();
		t_page();
		t_suspend();
		t_host();
		t_dma();
		t_arb();
		tally_and_finish(1'b0);
	end
endmodule : testbench
